//--- pkg/vfi_cfg.svh
`ifndef VFI_CFG_SVH
`define VFI_CFG_SVH

// =============================================
// Opcode values of the six handled forms
`define VFI_OPC_PROD 9'h06d
`define VFI_OPC_RECIP 9'h06e
`define VFI_OPC_RSQRT 9'h06f
`define VFI_OPC_SADD 9'h070
`define VFI_OPC_VADD 9'h071
`define VFI_OPC_SSUB 9'h072

// =============================================
// Timing in phases after issue, two phases per clock
`define VFI_PH_PER_CLK 2
`define VFI_PH_NEXT 2
`define VFI_PH_REG_FREE 5
`define VFI_PH_UNIT_FREE 8
`define VFI_PH_DEST_FMUL 39
`define VFI_PH_DEST_INT 27
`define VFI_PH_SRC_REL 17
`define VFI_PH_UNIT_REL 20
`define VFI_PH_PER_ELEM 2
`define VFI_REL_BASE_LEN 4

// =============================================
// Floating-point layout
`define VFI_EXP_BIAS 16'h4000
`define VFI_COEF_MSB 47
`define VFI_ITER_RECIP 2
`define VFI_ITER_RSQRT 3

`endif

//--- pkg/vfi_pkg.sv
package vfi_pkg;

    typedef enum logic [2:0] {
        VFI_OP_PROD = 3'b000,
        VFI_OP_RECIP = 3'b001,
        VFI_OP_RSQRT = 3'b010,
        VFI_OP_SADD = 3'b011,
        VFI_OP_VADD = 3'b100,
        VFI_OP_SSUB = 3'b101,
        VFI_OP_NONE = 3'b111
    } vfi_op_t;

    typedef enum logic [0:0] {
        VFI_ST_IDLE = 1'b0,
        VFI_ST_STREAM = 1'b1
    } vfi_state_t;

endpackage

//--- hdl/vfi_skid_buf.sv
`timescale 1ns/1ns
`default_nettype none

module vfi_skid_buf #(
    parameter int DW = 64,
    parameter int DEPTH = 2
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic inValid,
    input wire logic [DW-1:0] inData,
    output logic spaceNext,
    output logic outValid_r,
    output logic [DW-1:0] outData,
    input wire logic outReady
);
    localparam int CNTW = $clog2(DEPTH + 1);

    logic [DW-1:0] mem_r [DEPTH];
    logic [CNTW-1:0] cnt_r;
    logic [CNTW-1:0] cnt_nxt;
    wire logic pop = outValid_r && outReady;
    wire logic [CNTW-1:0] wrIdx = cnt_r - CNTW'(pop);

    assign cnt_nxt = cnt_r + CNTW'(inValid) - CNTW'(pop);
    // Lets the feeder register its ready one cycle ahead
    assign spaceNext = cnt_nxt < CNTW'(DEPTH);
    assign outData = mem_r[0];

    // =============================================
    // Shifting queue: the head always sits in entry 0
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_ent
            always_ff @(posedge ref_clk) begin
                if (inValid && wrIdx == CNTW'(g)) begin
                    mem_r[g] <= inData;
                end else if (pop && g < DEPTH - 1) begin
                    mem_r[g] <= mem_r[(g + 1) % DEPTH];
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cnt_r <= '0;
            outValid_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            outValid_r <= cnt_nxt != '0;
        end
    end

    chk_buf_no_overflow: assert property (@(posedge ref_clk) disable iff (reset)
        inValid |-> (cnt_r < CNTW'(DEPTH)) || pop)
        else $error("push into a full result buffer");

endmodule // vfi_skid_buf

`default_nettype wire

//--- hdl/vfi_elem_alu.sv
`timescale 1ns/1ns
`default_nettype none
`include "vfi_cfg.svh"

module vfi_elem_alu (
    input wire vfi_pkg::vfi_op_t op,
    input wire logic [63:0] scalar,
    input wire logic [63:0] elemJ,
    input wire logic [63:0] elemK,
    output logic [63:0] result
);
    // =============================================
    // Truncating product, a zero coefficient forces a zero result
    function automatic logic [63:0] fpMul(input logic [63:0] a,
                                          input logic [63:0] b);
        logic [95:0] pr;
        logic [15:0] ex;
        logic [63:0] r;
        pr = {48'h0, a[47:0]} * {48'h0, b[47:0]};
        ex = {1'b0, a[62:48]} + {1'b0, b[62:48]} - `VFI_EXP_BIAS;
        if (pr[95]) begin
            r = {a[63] ^ b[63], ex[14:0], pr[95:48]};
        end else begin
            r = {a[63] ^ b[63], ex[14:0] - 15'h1, pr[94:47]};
        end
        if (a[47:0] == '0 || b[47:0] == '0) begin
            r = '0;
        end
        return r;
    endfunction

    // Iteration term (c - p) / 2^half, in 53-bit fixed point
    function automatic logic [63:0] fpIter(input logic [63:0] p,
                                           input logic [1:0] c,
                                           input logic half);
        logic signed [16:0] sh;
        logic [52:0] fx;
        logic [52:0] cst;
        logic [52:0] df;
        logic neg;
        logic [5:0] pos;
        logic [15:0] ex;
        logic [52:0] nc;
        sh = $signed({2'b0, p[62:48]}) - $signed({1'b0, `VFI_EXP_BIAS});
        fx = {5'h0, p[47:0]};
        if (sh > 17'sd3) begin
            fx = '1;
        end else if (sh >= 17'sd0) begin
            fx = fx << sh[1:0];
        end else if (sh < -17'sd52) begin
            fx = '0;
        end else begin
            fx = fx >> 6'(-sh);
        end
        cst = {51'h0, c} << 48;
        neg = 1'b0;
        if (p[63]) begin
            df = cst + fx;
        end else if (fx > cst) begin
            df = fx - cst;
            neg = 1'b1;
        end else begin
            df = cst - fx;
        end
        pos = '0;
        for (int n = 0; n < 53; n++) begin
            if (df[n]) begin
                pos = 6'(n);
            end
        end
        if (pos >= 6'(`VFI_COEF_MSB)) begin
            nc = df >> (pos - 6'(`VFI_COEF_MSB));
        end else begin
            nc = df << (6'(`VFI_COEF_MSB) - pos);
        end
        ex = `VFI_EXP_BIAS + 16'(pos) - 16'(`VFI_COEF_MSB) - 16'(half);
        return (df == '0) ? 64'h0 : {neg, ex[14:0], nc[47:0]};
    endfunction

    wire logic [63:0] prod = fpMul(elemJ, elemK);

    // Pure function of one element pair, nothing carried over
    always_comb begin
        case (op)
            vfi_pkg::VFI_OP_PROD: result = prod;
            vfi_pkg::VFI_OP_RECIP:
                result = fpIter(prod, 2'(`VFI_ITER_RECIP), 1'b0);
            vfi_pkg::VFI_OP_RSQRT:
                result = fpIter(prod, 2'(`VFI_ITER_RSQRT), 1'b1);
            vfi_pkg::VFI_OP_SADD: result = scalar + elemK;
            vfi_pkg::VFI_OP_VADD: result = elemJ + elemK;
            vfi_pkg::VFI_OP_SSUB: result = scalar - elemK;
            default: result = '0;
        endcase
    end

endmodule // vfi_elem_alu

`default_nettype wire

//--- hdl/vfi_issue.sv
// Contract
// - 155 form yields 64-bit floating product
// - 156 form yields reciprocal iteration term
// - 157 form yields (3 - product) / 2
// - 160 form adds scalar to each element
// - 161 form adds paired vector elements
// - 162 form subtracts each element from scalar
// - element count equals vector length register
// - scalar read at issue, held throughout
// - elements computed independently, no carry
// - multiply issue needs regs@5, unit@8 free
// - integer issue needs regs@5, unit@8 free
// - next instruction in issue position phase 2
// - multiply destination free phase 39 at VL1
// - integer destination free phase 27 at VL1
// - destination plus two phases per extra element
// - sources phase 17, multiply unit phase 20
// - integer unit phase 20, sources phase 17
// - release plus two phases beyond fourth element
`timescale 1ns/1ns
`default_nettype none
`include "vfi_cfg.svh"

module vfi_issue #(
    parameter int VLW = 7,
    parameter int CW = 8,
    parameter int NREG = 8,
    parameter int DW = 64
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic instValid,
    input wire logic [8:0] instOpcode,
    input wire logic [2:0] instI,
    input wire logic [2:0] instJ,
    input wire logic [2:0] instK,
    input wire logic [VLW-1:0] vecLen,
    input wire logic [NREG-1:0] scalarFree,
    input wire logic [DW-1:0] scalarData,
    input wire logic opValid,
    input wire logic [DW-1:0] opJ,
    input wire logic [DW-1:0] opK,
    output logic opReady_r,
    output logic instTaken_r,
    output logic issueStall_r,
    output logic streamActive_r,
    output logic [2:0] srcVecJ_r,
    output logic [2:0] srcVecK_r,
    output logic [2:0] dstVec_r,
    output logic resValid,
    output logic [DW-1:0] resData,
    input wire logic resReady,
    output logic [NREG-1:0] vecFree_r,
    output logic fmulFree_r,
    output logic intFree_r
);
    localparam int PW = 10;
    localparam logic [CW-1:0] REG_SLACK =
        CW'(`VFI_PH_REG_FREE / `VFI_PH_PER_CLK);
    localparam logic [CW-1:0] UNIT_SLACK =
        CW'(`VFI_PH_UNIT_FREE / `VFI_PH_PER_CLK);

    // =============================================
    // Decode
    function automatic vfi_pkg::vfi_op_t decodeOp(input logic [8:0] opc);
        case (opc)
            `VFI_OPC_PROD: decodeOp = vfi_pkg::VFI_OP_PROD;
            `VFI_OPC_RECIP: decodeOp = vfi_pkg::VFI_OP_RECIP;
            `VFI_OPC_RSQRT: decodeOp = vfi_pkg::VFI_OP_RSQRT;
            `VFI_OPC_SADD: decodeOp = vfi_pkg::VFI_OP_SADD;
            `VFI_OPC_VADD: decodeOp = vfi_pkg::VFI_OP_VADD;
            `VFI_OPC_SSUB: decodeOp = vfi_pkg::VFI_OP_SSUB;
            default: decodeOp = vfi_pkg::VFI_OP_NONE;
        endcase
    endfunction

    // Release time in phases rounded up to whole clocks
    function automatic logic [CW-1:0] phToCyc(input logic [PW-1:0] ph);
        logic [PW-1:0] c;
        c = (ph + PW'(1)) >> 1;
        return CW'(c);
    endfunction

    function automatic logic [CW-1:0] maxCnt(input logic [CW-1:0] a,
                                             input logic [CW-1:0] b);
        return (a > b) ? a : b;
    endfunction

    logic [CW-1:0] vecCnt_r [NREG];
    logic [CW-1:0] fmulCnt_r;
    logic [CW-1:0] intCnt_r;
    vfi_pkg::vfi_state_t state_r;
    vfi_pkg::vfi_op_t streamOp_r;
    logic [DW-1:0] scalarReg_r;
    logic [VLW-1:0] vlReg_r;
    logic [VLW-1:0] elemCnt_r;

    wire vfi_pkg::vfi_op_t instOp = decodeOp(instOpcode);
    wire logic isFmul = instOp == vfi_pkg::VFI_OP_PROD ||
        instOp == vfi_pkg::VFI_OP_RECIP || instOp == vfi_pkg::VFI_OP_RSQRT;
    wire logic isScalar = instOp == vfi_pkg::VFI_OP_SADD ||
        instOp == vfi_pkg::VFI_OP_SSUB;
    wire logic isKnown = instOp != vfi_pkg::VFI_OP_NONE;

    // =============================================
    // Issue conditions
    wire logic destOk = vecCnt_r[instI] <= REG_SLACK;
    wire logic srcKOk = vecCnt_r[instK] <= REG_SLACK;
    wire logic srcJOk = isScalar ? scalarFree[instJ]
        : vecCnt_r[instJ] <= REG_SLACK;
    wire logic unitOk = isFmul ? fmulCnt_r <= UNIT_SLACK
        : intCnt_r <= UNIT_SLACK;
    // One shared element path, so a stream must end before the next one
    wire logic pathIdle = state_r == vfi_pkg::VFI_ST_IDLE;
    wire logic regsOk = destOk && srcKOk && srcJOk;
    wire logic canIssue = instValid && isKnown && regsOk && unitOk &&
        pathIdle;
    // A zero length still reserves as for one element
    wire logic [VLW-1:0] vlM1 = (vecLen == '0) ? '0
        : vecLen - VLW'(1);
    wire logic [VLW-1:0] vlExtra =
        (vecLen > VLW'(`VFI_REL_BASE_LEN))
        ? vecLen - VLW'(`VFI_REL_BASE_LEN) : '0;

    // =============================================
    // Reservation lengths
    wire logic [PW-1:0] destBase = isFmul ? PW'(`VFI_PH_DEST_FMUL)
        : PW'(`VFI_PH_DEST_INT);
    wire logic [PW-1:0] destPh = destBase +
        PW'(vlM1) * PW'(`VFI_PH_PER_ELEM);
    wire logic [PW-1:0] srcPh = PW'(`VFI_PH_SRC_REL) +
        PW'(vlExtra) * PW'(`VFI_PH_PER_ELEM);
    wire logic [PW-1:0] unitPh = PW'(`VFI_PH_UNIT_REL) +
        PW'(vlExtra) * PW'(`VFI_PH_PER_ELEM);
    wire logic [CW-1:0] destCyc = phToCyc(destPh);
    wire logic [CW-1:0] srcCyc = phToCyc(srcPh);
    wire logic [CW-1:0] unitCyc = phToCyc(unitPh);

    genvar r;
    generate
        for (r = 0; r < NREG; r++) begin : g_vreg
            wire logic [CW-1:0] dec = (vecCnt_r[r] == '0) ? '0
                : vecCnt_r[r] - CW'(1);
            wire logic hitD = canIssue && instI == 3'(r);
            wire logic hitS = canIssue && (instK == 3'(r) ||
                (!isScalar && instJ == 3'(r)));
            wire logic [CW-1:0] withD = hitD ? maxCnt(dec, destCyc) : dec;
            wire logic [CW-1:0] cntNxt = hitS ? maxCnt(withD, srcCyc)
                : withD;
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    vecCnt_r[r] <= '0;
                    vecFree_r[r] <= 1'b1;
                end else begin
                    vecCnt_r[r] <= cntNxt;
                    vecFree_r[r] <= cntNxt == '0;
                end
            end
        end
    endgenerate

    wire logic [CW-1:0] fmulDec = (fmulCnt_r == '0) ? '0
        : fmulCnt_r - CW'(1);
    wire logic [CW-1:0] intDec = (intCnt_r == '0) ? '0
        : intCnt_r - CW'(1);
    wire logic [CW-1:0] fmulCnt_nxt = (canIssue && isFmul)
        ? maxCnt(fmulDec, unitCyc) : fmulDec;
    wire logic [CW-1:0] intCnt_nxt = (canIssue && !isFmul)
        ? maxCnt(intDec, unitCyc) : intDec;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            fmulCnt_r <= '0;
            intCnt_r <= '0;
            fmulFree_r <= 1'b1;
            intFree_r <= 1'b1;
        end else begin
            fmulCnt_r <= fmulCnt_nxt;
            intCnt_r <= intCnt_nxt;
            fmulFree_r <= fmulCnt_nxt == '0;
            intFree_r <= intCnt_nxt == '0;
        end
    end

    // =============================================
    // Issue handshake: a taken pulse frees the position next clock
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            instTaken_r <= 1'b0;
            issueStall_r <= 1'b0;
        end else begin
            instTaken_r <= canIssue;
            issueStall_r <= instValid && !canIssue;
        end
    end

    // =============================================
    // Element stream
    wire logic accept = opReady_r && opValid;
    wire logic lastElem = elemCnt_r == vlReg_r - VLW'(1);
    wire logic bufSpace;
    logic [DW-1:0] aluRes;
    vfi_pkg::vfi_state_t state_nxt;

    always_comb begin
        case (state_r)
            vfi_pkg::VFI_ST_IDLE:
                state_nxt = (canIssue && vecLen != '0)
                    ? vfi_pkg::VFI_ST_STREAM : vfi_pkg::VFI_ST_IDLE;
            vfi_pkg::VFI_ST_STREAM:
                state_nxt = (accept && lastElem)
                    ? vfi_pkg::VFI_ST_IDLE : vfi_pkg::VFI_ST_STREAM;
            default: state_nxt = vfi_pkg::VFI_ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_r <= vfi_pkg::VFI_ST_IDLE;
            streamActive_r <= 1'b0;
            opReady_r <= 1'b0;
            elemCnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            streamActive_r <= state_nxt == vfi_pkg::VFI_ST_STREAM;
            opReady_r <= state_nxt == vfi_pkg::VFI_ST_STREAM && bufSpace;
            elemCnt_r <= canIssue ? '0
                : elemCnt_r + VLW'(accept);
        end
    end

    // Scalar is latched once so later scalar writes cannot leak in
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            streamOp_r <= vfi_pkg::VFI_OP_NONE;
            scalarReg_r <= '0;
            vlReg_r <= '0;
            srcVecJ_r <= '0;
            srcVecK_r <= '0;
            dstVec_r <= '0;
        end else if (canIssue) begin
            streamOp_r <= instOp;
            scalarReg_r <= scalarData;
            vlReg_r <= vecLen;
            srcVecJ_r <= instJ;
            srcVecK_r <= instK;
            dstVec_r <= instI;
        end
    end

    vfi_elem_alu u_alu (
        .op(streamOp_r),
        .scalar(scalarReg_r),
        .elemJ(opJ),
        .elemK(opK),
        .result(aluRes)
    );

    vfi_skid_buf #(.DW(DW), .DEPTH(2)) u_buf (
        .ref_clk(ref_clk),
        .reset(reset),
        .inValid(accept),
        .inData(aluRes),
        .spaceNext(bufSpace),
        .outValid_r(resValid),
        .outData(resData),
        .outReady(resReady)
    );

    // =============================================
    // Checks
    chk_issue_gated: assert property (@(posedge ref_clk) disable iff (reset)
        instTaken_r |-> $past(regsOk && unitOk))
        else $error("issued with a busy register or unit");
    chk_fmul_dest_vl1: assert property (@(posedge ref_clk)
        disable iff (reset)
        instTaken_r && $past(isFmul && vecLen == 7'h01)
        |-> vecCnt_r[$past(instI)] == 8'h14)
        else $error("multiply destination not held 20 clocks");
    chk_int_dest_vl1: assert property (@(posedge ref_clk)
        disable iff (reset)
        instTaken_r && $past(!isFmul && vecLen == 7'h01)
        |-> vecCnt_r[$past(instI)] == 8'h0e)
        else $error("integer destination not held 14 clocks");
    chk_dest_per_elem: assert property (@(posedge ref_clk)
        disable iff (reset)
        instTaken_r && $past(!isFmul && vecLen == 7'h05)
        |-> vecCnt_r[$past(instI)] == 8'h12)
        else $error("destination hold not extended per element");
    chk_unit_short: assert property (@(posedge ref_clk) disable iff (reset)
        instTaken_r && $past(isFmul && vecLen == 7'h04)
        |-> fmulCnt_r == 8'h0a ##6 fmulCnt_r == 8'h04)
        else $error("multiply unit not released at phase 20");
    chk_unit_long: assert property (@(posedge ref_clk) disable iff (reset)
        instTaken_r && $past(!isFmul && vecLen == 7'h07)
        |-> intCnt_r == 8'h0d)
        else $error("integer unit release not extended");
    chk_hold_stall: assert property (@(posedge ref_clk) disable iff (reset)
        instValid && isKnown && !(regsOk && unitOk)
        |=> issueStall_r && !instTaken_r)
        else $error("stalled instruction reported as taken");
    chk_elem_count: assert property (@(posedge ref_clk) disable iff (reset)
        $fell(streamActive_r) |-> elemCnt_r == vlReg_r)
        else $error("stream length differs from vector length");
    chk_scalar_held: assert property (@(posedge ref_clk)
        disable iff (reset)
        streamActive_r && $past(streamActive_r) && !instTaken_r
        |-> $stable(scalarReg_r))
        else $error("scalar operand changed during stream");

endmodule // vfi_issue

`default_nettype wire

//--- tb/vfi_src_model.sv
`timescale 1ns/1ns
`default_nettype none

// =============================================
// Source register file model: hands out element pairs
module vfi_src_model (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic opReady_r,
    input wire logic slow,
    output logic opValid,
    output logic [63:0] opJ,
    output logic [63:0] opK
);
    logic [63:0] qJ[$];
    logic [63:0] qK[$];
    logic took;
    logic [31:0] lfsr;

    task automatic push(input logic [63:0] j, input logic [63:0] k);
        qJ.push_back(j);
        qK.push_back(k);
    endtask

    initial begin
        opValid = 1'b0;
        opJ = 64'h0;
        opK = 64'h0;
        took = 1'b0;
        lfsr = 32'h0000_00a5;
    end

    always @(posedge ref_clk) took <= opValid && opReady_r && !reset;

    // A pair is held until taken; idle lines toggle so stale data never
    // looks valid
    always @(negedge ref_clk) begin
        if (took) begin
            void'(qJ.pop_front());
            void'(qK.pop_front());
        end
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        if (opValid && !took) begin
            opValid = 1'b1;
        end else if (qJ.size() != 0 && !(slow && lfsr[0])) begin
            opValid = 1'b1;
            opJ = qJ[0];
            opK = qK[0];
        end else begin
            opValid = 1'b0;
            opJ = ~opJ;
            opK = ~opK;
        end
    end
endmodule // vfi_src_model

`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "vfi_cfg.svh"

module testbench;
    localparam logic [63:0] fOne = 64'h4001_8000_0000_0000;
    localparam logic [63:0] fHalf = 64'h4000_8000_0000_0000;
    localparam logic [63:0] fOneHalf = 64'h4001_c000_0000_0000;
    localparam logic [63:0] fOneQtr = 64'h4001_a000_0000_0000;
    logic ref_clk, reset, instValid, opValid, opReady_r, instTaken_r;
    logic issueStall_r, streamActive_r, resValid, resReady, fmulFree_r;
    logic intFree_r, slow, fastSink;
    logic [8:0] instOpcode;
    logic [2:0] instI, instJ, instK, srcVecJ_r, srcVecK_r, dstVec_r, b;
    logic [6:0] vecLen;
    logic [7:0] scalarFree, vecFree_r;
    logic [63:0] scalarData, opJ, opK, resData;
    logic [63:0] resQ[$];
    logic [15:0] sinkSt;
    logic [31:0] seed;
    logic [8:0] opc[6] = '{`VFI_OPC_PROD, `VFI_OPC_RECIP, `VFI_OPC_RSQRT,
        `VFI_OPC_SADD, `VFI_OPC_VADD, `VFI_OPC_SSUB};
    int errors, n_checks, cyc, takeCyc, c0, n;

    vfi_issue u_vfi_issue (.ref_clk(ref_clk), .reset(reset),
        .instValid(instValid), .instOpcode(instOpcode), .instI(instI),
        .instJ(instJ), .instK(instK), .vecLen(vecLen),
        .scalarFree(scalarFree), .scalarData(scalarData),
        .opValid(opValid), .opJ(opJ), .opK(opK), .opReady_r(opReady_r),
        .instTaken_r(instTaken_r), .issueStall_r(issueStall_r),
        .streamActive_r(streamActive_r), .srcVecJ_r(srcVecJ_r),
        .srcVecK_r(srcVecK_r), .dstVec_r(dstVec_r), .resValid(resValid),
        .resData(resData), .resReady(resReady), .vecFree_r(vecFree_r),
        .fmulFree_r(fmulFree_r), .intFree_r(intFree_r));

    vfi_src_model u_vfi_src_model (.ref_clk(ref_clk), .reset(reset),
        .opReady_r(opReady_r), .slow(slow), .opValid(opValid), .opJ(opJ),
        .opK(opK));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // =============================================
    // Destination sink, with periodic long stalls to fill the buffer
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (!reset && resValid && resReady) resQ.push_back(resData);
    end
    always @(negedge ref_clk) begin
        sinkSt <= {sinkSt[14:0],
            sinkSt[15] ^ sinkSt[13] ^ sinkSt[12] ^ sinkSt[10]};
        resReady <= fastSink || (sinkSt[1:0] != 2'b00 && cyc % 32 > 9);
    end

    // =============================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [63:0] fnum();
        logic [31:0] a, c;
        a = rnd();
        c = rnd();
        return {a[31], 15'h3ff8 + {11'h0, a[3:0]}, 1'b1, a[30:4], c[19:0]};
    endfunction

    // Truncating product, one normalising step at most
    function automatic logic [63:0] fprod(input logic [63:0] a,
            input logic [63:0] c);
        logic [95:0] m;
        logic [15:0] e;
        m = a[47:0] * c[47:0];
        e = {1'b0, a[62:48]} + {1'b0, c[62:48]} - 16'h4000;
        if (m[95]) return {a[63] ^ c[63], e[14:0], m[95:48]};
        return {a[63] ^ c[63], e[14:0] - 15'h1, m[94:47]};
    endfunction

    function automatic logic [63:0] want_res(input int oi,
            input logic [63:0] s, input logic [63:0] j,
            input logic [63:0] k);
        case (oi)
            0: return fprod(j, k);
            1: return (k == fHalf) ? fOneHalf : fOne;
            2: return (k == fHalf) ? fOneQtr : fOne;
            3: return s + k;
            4: return j + k;
            default: return s - k;
        endcase
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        n_checks++;
        if (seen !== want) begin
            errors++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic complete_run();
        if (errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic timeout();
        errors++;
        $display("BAD %0t wait ran out", $time);
        complete_run();
    endtask

    // Mode 0 full timing check, 1 return once results are in, 2 hold
    // the scalar busy first
    task automatic run_op(input int oi, input int vl, input logic [2:0] i,
            input logic [2:0] j, input logic [2:0] k, input int mode);
        logic [63:0] s, a, c;
        logic [63:0] want[$];
        int t, tD, tS, tJ, tU, d, sr;
        s = {rnd(), rnd()};
        for (t = 0; t < vl; t++) begin
            a = {rnd(), rnd()};
            c = (t == 0) ? 64'hffff_ffff_ffff_ffff : {rnd(), rnd()};
            if (oi == 0) begin
                a = fnum();
                c = fnum();
            end else if (oi < 3) begin
                a = fOne;
                c = (rnd() & 32'h1) != 0 ? fHalf : fOne;
            end
            u_vfi_src_model.push(a, c);
            want.push_back(want_res(oi, s, a, c));
        end
        d = (oi < 3) ? 19 + vl : 13 + vl;
        sr = 9 + (vl > 4 ? vl - 4 : 0);
        resQ.delete();
        slow <= (rnd() & 32'h1) != 0 && mode == 0;
        @(negedge ref_clk);
        instValid = 1'b1;
        instOpcode = opc[oi];
        {instI, instJ, instK} = {i, j, k};
        vecLen = 7'(vl);
        scalarData = s;
        if (mode == 2) begin
            scalarFree[j] = 1'b0;
            repeat (6) @(negedge ref_clk);
            check({instTaken_r, issueStall_r}, 2'b01);
            scalarFree[j] = 1'b1;
        end
        for (t = 0; t < 100 && instTaken_r !== 1'b1; t++) @(negedge ref_clk);
        if (t == 100) timeout();
        takeCyc = cyc;
        instValid = 1'b0;
        scalarData = ~s;
        check({dstVec_r, srcVecJ_r, srcVecK_r}, {i, j, k});
        {tD, tS, tJ, tU} = {-32'sd1, -32'sd1, -32'sd1, -32'sd1};
        for (t = 0; t < 300; t++) begin
            if (t > 0) @(negedge ref_clk);
            if (t == 0) check(64'(opReady_r), 64'h1);
            if (t == 1) check(64'(instTaken_r), 64'h0);
            if (tD < 0 && vecFree_r[i]) tD = t;
            if (tS < 0 && vecFree_r[k]) tS = t;
            if (tJ < 0 && vecFree_r[j]) tJ = t;
            if (tU < 0 && (oi < 3 ? fmulFree_r : intFree_r)) tU = t;
            if (resQ.size() == vl && (mode == 1 || t > d + 2)) break;
        end
        if (t == 300) timeout();
        check(64'(resQ.size()), 64'(vl));
        for (t = 0; t < vl; t++) begin
            check(resQ[t],
                want[t]);
        end
        if (mode != 1) begin
            check(64'(tD), 64'(d));
            check(64'(tS), 64'(sr));
            if (oi != 3 && oi != 5) check(64'(tJ), 64'(sr));
            check(64'(tU), 64'(sr + 1));
        end
    endtask

    // =============================================
    // Main sequence
    initial begin
        {errors, n_checks, cyc} = 96'h0;
        seed = 32'h1bf65c48;
        sinkSt = 16'hace1;
        {reset, instValid, resReady, slow, fastSink} = 5'b10000;
        {instOpcode, instI, instJ, instK, vecLen} = 25'h0;
        scalarFree = 8'hff;
        scalarData = 64'h0;
        repeat (6) @(negedge ref_clk);
        reset = 1'b0;
        for (n = 0; n < 30; n++) begin
            b = 3'(rnd());
            run_op(n % 6, n < 6 ? n + 1 : 1 + rnd() % 12, b, b + 3'd1,
                b + 3'd2, 0);
        end
        run_op(3, 7, 3'd6, 3'd2, 3'd7, 2);
        run_op(5, 5, 3'd0, 3'd5, 3'd1, 2);
        fastSink = 1'b1;
        run_op(3, 1, 3'd1, 3'd2, 3'd3, 1);
        c0 = takeCyc;
        run_op(4, 1, 3'd4, 3'd5, 3'd1, 0);
        check(64'(takeCyc - c0), 64'd13);
        run_op(0, 4, 3'd1, 3'd2, 3'd3, 1);
        c0 = takeCyc;
        run_op(1, 1, 3'd4, 3'd5, 3'd1, 0);
        check(64'(takeCyc - c0), 64'd22);
        fastSink = 1'b0;
        @(negedge ref_clk);
        instValid = 1'b1;
        instOpcode = 9'h06c;
        repeat (12) @(negedge ref_clk);
        check({instTaken_r, issueStall_r, streamActive_r}, 3'b010);
        instValid = 1'b0;
        repeat (4) @(negedge ref_clk);
        complete_run();
    end
endmodule // testbench

`default_nettype wire
